//--- logic/lsn_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsn_params.svh"
// Contract
// R1: Train at 2.5, upgrade only in L0 both-advertised
// R2: Rate upgrade never reports data link down
// R3: Advertise supported rates in training sets
// R4: Record partner rates; newest advertisement wins
// R5: Hold lower of target and common maximum
// R6: No upgrade without recorded partner support
// R7: Wait 200 ms after failure, unless re-advertised
// R8: Retrain with different target starts rate change
// R9: Target resets to 5.0, advertise both
// R10: Auto upgrade after reaching L0 at 2.5
// R11: First auto upgrade leaves bandwidth flag clear
// R12: Report current rate read-only
// R13: Downgrade on unreliability, keep advertising high
// R14: Target 2.5 plus retrain: downgrade, stop advertising
// R15: Always answer partner rate change requests
// R16: After failed upgrade, no autonomous retry
// R17: No support recorded: recovery without speed change
// R18: Flag on reliability downgrade or non-autonomous partner change
// R19: Flag set on every software retrain
// R20: Autonomous flag on partner autonomous change
// R21: Interrupt only while enable bit set
// R22: Autonomous disable bit reads zero, no effect
// R23: Rate encoding 1 = 2.5, 2 = 5.0
module lsn_port import lsn_pkg::*; #(
    parameter int RETRY_CYC = `LSN_RETRY_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    lsn_link_if.port link,
    // Training state machine side
    input wire logic isDownstream,
    input wire logic fullRetrain,
    input wire logic trainDone,
    input wire logic unreliable,
    input wire logic lockFail,
    // Software fields
    input wire logic targetWrEn,
    input wire logic [1:0] targetWrData,
    input wire logic retrainReq,
    input wire logic bwIrqEnable,
    input wire logic bwStatusClr,
    input wire logic autoBwStatusClr,
    output logic [1:0] targetRate,
    output logic [1:0] currentRate,
    output logic bwMgmtStatus,
    output logic autoBwStatus,
    output logic hwAutoRateDisable,
    output logic bwIrq,
    output logic linkUp
);
    lsn_ltssm_t st_r, st_nxt;
    logic [1:0] tgt_r, tgt_nxt, cur_r, cur_nxt;
    logic pHi_r, pHi_nxt;          // Partner high-rate support recorded since Detect
    logic firstUp_r, firstUp_nxt;  // First automatic upgrade still pending
    logic failed_r, failed_nxt;    // Upgrade failed, hold off autonomous retry
    logic [31:0] wait_r, wait_nxt;
    logic chg_r, chg_nxt;          // Sending speed change request
    logic why_r, why_nxt;          // 1 = software-driven, 0 = autonomous
    logic bw_r, bw_nxt, abw_r, abw_nxt;

    function automatic logic isHigh(input logic [1:0] r);
        isHigh = (r == `LSN_RATE_HIGH);
    endfunction : isHigh

    // Training state, rate and flag updates
    always_comb begin
        st_nxt = st_r;
        tgt_nxt = targetWrEn ? targetWrData : tgt_r;
        cur_nxt = cur_r;
        pHi_nxt = pHi_r;
        firstUp_nxt = firstUp_r;
        failed_nxt = failed_r;
        wait_nxt = (wait_r != 32'h0) ? wait_r - 32'h1 : wait_r;
        chg_nxt = chg_r;
        why_nxt = why_r;
        bw_nxt = bw_r && !bwStatusClr;
        abw_nxt = abw_r && !autoBwStatusClr;
        // New partner advertisement cancels the retry hold-off [R7]
        if (link.upTsValid && link.upHiAdv && !pHi_r) begin
            wait_nxt = 32'h0;
        end
        // Record newest partner rates in config-complete and rcvr-cfg [R4]
        if (link.upTsValid && (st_r == LSN_TRAIN || st_r == LSN_RECOVERY)) begin
            pHi_nxt = link.upHiAdv;
        end
        if (fullRetrain) begin
            st_nxt = LSN_DETECT;
        end else begin
            case (st_r)
                LSN_DETECT: begin
                    cur_nxt = `LSN_RATE_LOW;  // [R1]
                    pHi_nxt = 1'b0;
                    firstUp_nxt = 1'b1;
                    failed_nxt = 1'b0;
                    chg_nxt = 1'b0;
                    st_nxt = LSN_TRAIN;
                end
                LSN_TRAIN: begin
                    if (trainDone) begin
                        st_nxt = LSN_L0;
                    end
                end
                LSN_L0: begin
                    if (retrainReq) begin
                        // Speed change only with a differing target, and with recorded support when the target is 5.0 [R8] [R17] [R14]
                        chg_nxt = (tgt_r != cur_r) && (pHi_r || !isHigh(tgt_r));
                        why_nxt = 1'b1;
                        bw_nxt = bw_nxt || isDownstream;  // [R19]
                        st_nxt = LSN_RECOVERY;
                    end else if (isHigh(cur_r) && unreliable) begin
                        // Rate drops when recovery ends, so it cannot be mistaken for an upgrade there
                        chg_nxt = 1'b1;  // [R13]
                        why_nxt = 1'b0;
                        bw_nxt = bw_nxt || isDownstream;  // [R18]
                        st_nxt = LSN_RECOVERY;
                    end else if (link.upSpeedChg) begin
                        st_nxt = LSN_RECOVERY;  // [R15]
                        chg_nxt = 1'b0;
                        if (link.upAuto) begin
                            abw_nxt = abw_nxt || isDownstream;  // [R20]
                        end else begin
                            bw_nxt = bw_nxt || isDownstream;  // [R18]
                        end
                        if (link.upHiOk && link.upHiAdv) begin
                            cur_nxt = isHigh(cur_r) ? `LSN_RATE_LOW : `LSN_RATE_HIGH;
                        end
                    end else if (!isHigh(cur_r) && isHigh(tgt_r) && pHi_r && (wait_r == 32'h0)
                                 && firstUp_r && !failed_r) begin
                        // Only once per Detect: a partner or reliability downgrade then sticks
                        // Autonomous upgrade, only after L0 with recorded support [R10] [R6] [R5] [R16]
                        chg_nxt = 1'b1;
                        why_nxt = 1'b0;
                        st_nxt = LSN_RECOVERY;
                    end
                end
                LSN_RECOVERY: begin
                    // Recovery keeps the data link up; no pass through Detect [R2]
                    if (link.upAck) begin
                        st_nxt = LSN_L0;
                        if (chg_r && isHigh(tgt_r) && !isHigh(cur_r)) begin
                            if (link.upHiOk && !lockFail) begin
                                cur_nxt = `LSN_RATE_HIGH;  // [R1]
                            end else begin
                                failed_nxt = 1'b1;  // [R16]
                                wait_nxt = RETRY_CYC;  // [R7]
                            end
                            firstUp_nxt = 1'b0;  // [R11]
                        end else if (chg_r && (!why_r || !isHigh(tgt_r))) begin
                            cur_nxt = `LSN_RATE_LOW;  // [R13] [R14]
                        end
                        chg_nxt = 1'b0;
                    end
                end
                default: st_nxt = LSN_DETECT;
            endcase
        end
        // Hardware set wins over software clear
        if (bwStatusClr && bw_r && bw_nxt) begin
            bw_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LSN_DETECT;
            tgt_r <= `LSN_RATE_RESET;  // [R9]
            cur_r <= `LSN_RATE_LOW;
            pHi_r <= 1'b0;
            firstUp_r <= 1'b1;
            failed_r <= 1'b0;
            wait_r <= 32'h0;
            chg_r <= 1'b0;
            why_r <= 1'b0;
            bw_r <= 1'b0;
            abw_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tgt_r <= tgt_nxt;
            cur_r <= cur_nxt;
            pHi_r <= pHi_nxt;
            firstUp_r <= firstUp_nxt;
            failed_r <= failed_nxt;
            wait_r <= wait_nxt;
            chg_r <= chg_nxt;
            why_r <= why_nxt;
            bw_r <= bw_nxt;
            abw_r <= abw_nxt;
        end
    end

    // Training sets: high rate advertised unless target is 2.5 [R3] [R9] [R14] [R13]
    assign link.dnTsValid = (st_r == LSN_TRAIN) || (st_r == LSN_RECOVERY);
    assign link.dnHiAdv = isHigh(tgt_r);
    assign link.dnSpeedChg = chg_r && (st_r == LSN_RECOVERY);
    assign link.dnAuto = 1'b0;

    // Software visible fields [R12] [R23] [R22] [R21]
    assign targetRate = tgt_r;
    assign currentRate = cur_r;
    assign bwMgmtStatus = bw_r;
    assign autoBwStatus = abw_r;
    assign hwAutoRateDisable = `LSN_RATE_DIS_VAL;
    assign bwIrq = isDownstream && bwIrqEnable && (bw_r || abw_r);
    assign linkUp = (st_r == LSN_L0) || (st_r == LSN_RECOVERY);
endmodule : lsn_port
`default_nettype wire

//--- logic/lsn_params.svh
`ifndef LSN_PARAMS_SVH
`define LSN_PARAMS_SVH

// Rate field encodings (1 = 2.5 GT/s, 2 = 5.0 GT/s)
`define LSN_RATE_LOW 2'h1
`define LSN_RATE_HIGH 2'h2
`define LSN_RATE_RESET 2'h2
// Retry hold-off after a failed upgrade
`define LSN_RETRY_MS 200
`define LSN_CLK_MHZ 250
`define LSN_RETRY_CYC (`LSN_RETRY_MS * 1000 * `LSN_CLK_MHZ)
// Cycles the far end waits in recovery before answering
`define LSN_FAR_LAT 4'h4
// Hardwired value of the autonomous rate disable bit
`define LSN_RATE_DIS_VAL 1'h0

`endif

//--- logic/lsn_pkg.sv
`default_nettype none
package lsn_pkg;
    // Link training state seen by the negotiation logic
    typedef enum logic [2:0] {
        LSN_DETECT,
        LSN_TRAIN,
        LSN_L0,
        LSN_RECOVERY
    } lsn_ltssm_t;

    // Local upgrade/downgrade sequencer
    typedef enum logic [1:0] {
        LSN_IDLE,
        LSN_WAIT,
        LSN_HOLD
    } lsn_seq_t;
endpackage : lsn_pkg
`default_nettype wire

//--- logic/lsn_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Training-set exchange between the port and its partner, abstracted to rate fields
interface lsn_link_if;
    logic dnTsValid;    // Port sends a training set
    logic dnHiAdv;      // Port advertises 5.0 GT/s
    logic dnSpeedChg;   // Speed change bit in port's sets
    logic dnAuto;       // Autonomous change bit (port never sets it)
    logic upTsValid;    // Partner sends a training set
    logic upHiAdv;      // Partner advertises 5.0 GT/s
    logic upSpeedChg;   // Partner requests a rate change
    logic upAuto;       // Partner marks change as autonomous
    logic upAck;        // Partner completes recovery
    logic upHiOk;       // Partner locked at the higher rate
    modport port (output dnTsValid, output dnHiAdv, output dnSpeedChg, output dnAuto,
                  input upTsValid, input upHiAdv, input upSpeedChg, input upAuto, input upAck, input upHiOk);
    modport partner (input dnTsValid, input dnHiAdv, input dnSpeedChg, input dnAuto,
                     output upTsValid, output upHiAdv, output upSpeedChg, output upAuto, output upAck,
                     output upHiOk);
endinterface : lsn_link_if
`default_nettype wire

//--- logic/lsn_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsn_params.svh"
// Far end: advertises, answers requests, can start its own rate change
module lsn_partner import lsn_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    lsn_link_if.partner link,
    // User side
    input wire logic hiCapable,
    input wire logic hiReliable,
    input wire logic reqChange,
    input wire logic reqAuto,
    input wire logic reqHigh,
    output logic busy
);
    logic [3:0] cnt_r, cnt_nxt;
    logic act_r, act_nxt;
    logic chg_r, chg_nxt;
    logic auto_r, auto_nxt;

    // Partner requests a change only toward a rate it advertises [R3] [R6]
    always_comb begin
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        chg_nxt = chg_r;
        auto_nxt = auto_r;
        if (act_r) begin
            if (cnt_r == 4'h0) begin
                act_nxt = 1'b0;
                chg_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r - 4'h1;
            end
        end else if (link.dnTsValid) begin
            act_nxt = 1'b1;
            cnt_nxt = `LSN_FAR_LAT;
        end else if (reqChange && (hiCapable || !reqHigh)) begin
            act_nxt = 1'b1;
            chg_nxt = 1'b1;
            auto_nxt = reqAuto;
            cnt_nxt = `LSN_FAR_LAT;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            act_r <= 1'b0;
            chg_r <= 1'b0;
            auto_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            chg_r <= chg_nxt;
            auto_r <= auto_nxt;
        end
    end

    // Higher rate succeeds only if both advertise and the channel is good [R1] [R15]
    assign link.upTsValid = act_r;
    assign link.upHiAdv = hiCapable;
    assign link.upSpeedChg = chg_r;
    assign link.upAuto = auto_r;
    assign link.upAck = act_r && (cnt_r == 4'h0);
    assign link.upHiOk = hiCapable && hiReliable && link.dnHiAdv;
    assign busy = act_r;
endmodule : lsn_partner
`default_nettype wire

//--- test/lsn_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsn_params.svh"
module lsn_link_sva import lsn_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link wires
    input wire logic dnTsValid,
    input wire logic dnHiAdv,
    input wire logic dnSpeedChg,
    input wire logic upTsValid,
    input wire logic upHiAdv,
    input wire logic upAuto,
    input wire logic upHiOk,
    // Port status
    input wire logic [1:0] targetRate,
    input wire logic [1:0] currentRate,
    input wire logic autoBwStatus,
    input wire logic hwAutoRateDisable,
    input wire logic linkUp
);
    logic seenHi_r, seenHi_nxt, seenAuto_r, seenAuto_nxt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Partner marks seen since reset; never forgotten, so they only loosen the checks
    always_comb begin
        seenHi_nxt = seenHi_r | (upTsValid & upHiAdv);
        seenAuto_nxt = seenAuto_r | upAuto;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seenHi_r <= 1'h0;
            seenAuto_r <= 1'h0;
        end else begin
            seenHi_r <= seenHi_nxt;
            seenAuto_r <= seenAuto_nxt;
        end
    end
    // Training sets carry the high rate exactly while the target asks for it
    tx_hi_adv_a: assert property (dnTsValid && $stable(targetRate) |-> dnHiAdv == (targetRate == `LSN_RATE_HIGH))
        else $error("advertised rate disagrees with target");
    rate_code_a: assert property (currentRate inside {`LSN_RATE_LOW, `LSN_RATE_HIGH})
        else $error("current rate code out of range");
    rate_dis_zero_a: assert property (hwAutoRateDisable == `LSN_RATE_DIS_VAL)
        else $error("autonomous disable bit not zero");
    link_stays_up_a: assert property (dnSpeedChg |-> linkUp)
        else $error("link down during rate change");
    upgrade_adv_a: assert property ($rose(dnSpeedChg) && currentRate == `LSN_RATE_LOW |-> seenHi_r)
        else $error("upgrade started without partner support");
    rise_needs_ok_a: assert property (currentRate == `LSN_RATE_HIGH && $past(currentRate) == `LSN_RATE_LOW |-> $past(upHiOk) && $past(linkUp))
        else $error("rate raised without lock or outside L0");
    hi_needs_adv_a: assert property (currentRate == `LSN_RATE_HIGH |-> seenHi_r)
        else $error("high rate without partner advertisement");
    auto_flag_a: assert property ($rose(autoBwStatus) |-> seenAuto_r)
        else $error("autonomous flag without autonomous change");
endmodule : lsn_link_sva
`default_nettype wire

//--- test/link_speed_negotiation_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsn_params.svh"
module link_speed_negotiation_bench import lsn_pkg::*;;
    typedef struct packed {
        logic [3:0] far;     // Partner request, autonomous, high; unreliable
        logic [1:0] tgt;     // Target to write, 0 writes nothing
        logic sw;
        logic [1:0] expCur;
        logic expBw;
        logic expAuto;
    } lsn_row_t;
    // Order matters: each row starts from the rate the one before left
    localparam lsn_row_t ROWS [5] = '{
        '{4'h8, 2'h0, 1'h0, `LSN_RATE_LOW, 1'h1, 1'h0},
        '{4'hE, 2'h0, 1'h0, `LSN_RATE_HIGH, 1'h0, 1'h1},
        '{4'h1, 2'h0, 1'h0, `LSN_RATE_LOW, 1'h1, 1'h0},
        '{4'h0, `LSN_RATE_HIGH, 1'h1, `LSN_RATE_HIGH, 1'h1, 1'h0},
        '{4'h0, `LSN_RATE_LOW, 1'h1, `LSN_RATE_LOW, 1'h1, 1'h0}
    };
    logic clk = 1'h0, rst_n = 1'h0, isDownstream = 1'h1, lockFail = 1'h0;
    logic fullRetrain = 1'h0, trainDone = 1'h0, unreliable = 1'h0, targetWrEn = 1'h0, retrainReq = 1'h0;
    logic bwIrqEnable = 1'h0, bwStatusClr = 1'h0, autoBwStatusClr = 1'h0;
    logic hiCapable = 1'h1, hiReliable = 1'h1, reqChange = 1'h0, reqAuto = 1'h0, reqHigh = 1'h0;
    logic [1:0] targetWrData = 2'h0, targetRate, currentRate;
    logic bwMgmtStatus, autoBwStatus, hwAutoRateDisable, bwIrq, linkUp;
    int failCount = 0;
    int totalChecks = 0;
    lsn_link_if lsn_link_if_i ();
    // Short hold-off keeps the failed-upgrade case brief
    lsn_port #(.RETRY_CYC(20)) lsn_port_i (.clk(clk), .rst_n(rst_n), .link(lsn_link_if_i),
        .isDownstream(isDownstream), .fullRetrain(fullRetrain), .trainDone(trainDone), .unreliable(unreliable),
        .lockFail(lockFail), .targetWrEn(targetWrEn), .targetWrData(targetWrData), .retrainReq(retrainReq),
        .bwIrqEnable(bwIrqEnable), .bwStatusClr(bwStatusClr), .autoBwStatusClr(autoBwStatusClr),
        .targetRate(targetRate), .currentRate(currentRate), .bwMgmtStatus(bwMgmtStatus),
        .autoBwStatus(autoBwStatus), .hwAutoRateDisable(hwAutoRateDisable), .bwIrq(bwIrq), .linkUp(linkUp));
    lsn_partner lsn_partner_i (.clk(clk), .rst_n(rst_n), .link(lsn_link_if_i), .hiCapable(hiCapable),
        .hiReliable(hiReliable), .reqChange(reqChange), .reqAuto(reqAuto), .reqHigh(reqHigh), .busy());
    lsn_link_sva lsn_link_sva_i (.clk(clk), .rst_n(rst_n), .dnTsValid(lsn_link_if_i.dnTsValid),
        .dnHiAdv(lsn_link_if_i.dnHiAdv), .dnSpeedChg(lsn_link_if_i.dnSpeedChg),
        .upTsValid(lsn_link_if_i.upTsValid), .upHiAdv(lsn_link_if_i.upHiAdv), .upAuto(lsn_link_if_i.upAuto),
        .upHiOk(lsn_link_if_i.upHiOk), .targetRate(targetRate), .currentRate(currentRate),
        .autoBwStatus(autoBwStatus), .hwAutoRateDisable(hwAutoRateDisable), .linkUp(linkUp));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input string what, input logic [1:0] expv, input logic [1:0] got);
        totalChecks++;
        if (got !== expv) begin
            failCount++;
            $display("wrong value %s expected %0h seen %0h", what, expv, got);
        end
    endtask : chk
    task automatic conclude;
        if (failCount == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    // Far end answers within its fixed latency; 20 cycles leaves margin
    task automatic runRow(input lsn_row_t r);
        @(posedge clk);
        targetWrEn <= (r.tgt != 2'h0);
        targetWrData <= r.tgt;
        @(posedge clk);
        targetWrEn <= 1'h0;
        retrainReq <= r.sw;
        {reqChange, reqAuto, reqHigh, unreliable} <= r.far;
        @(posedge clk);
        retrainReq <= 1'h0;
        reqChange <= 1'h0;
        repeat (20) @(posedge clk);
        #1;
    endtask : runRow
    task automatic clearFlags;
        @(posedge clk);
        unreliable <= 1'h0;
        {bwStatusClr, autoBwStatusClr} <= 2'h3;
        @(posedge clk);
        {bwStatusClr, autoBwStatusClr} <= 2'h0;
        @(posedge clk);
        #1;
    endtask : clearFlags
    // Training must last long enough for the partner's sets to be recorded
    task automatic fullTrain(input int cycles);
        @(posedge clk);
        fullRetrain <= 1'h1;
        trainDone <= 1'h0;
        @(posedge clk);
        fullRetrain <= 1'h0;
        repeat (10) @(posedge clk);
        trainDone <= 1'h1;
        repeat (cycles) @(posedge clk);
        #1;
    endtask : fullTrain
    // Watchdog: over twenty times the length of the sequence
    initial begin
        #40000;
        failCount++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk("targetRate", `LSN_RATE_RESET, targetRate);
        chk("currentRate", `LSN_RATE_LOW, currentRate);
        chk("flags", 2'h0, {bwMgmtStatus, autoBwStatus});
        chk("hwAutoRateDisable", {1'h0, `LSN_RATE_DIS_VAL}, {1'h0, hwAutoRateDisable});
        @(posedge clk);
        rst_n <= 1'h1;
        repeat (10) @(posedge clk);
        trainDone <= 1'h1;
        for (int i = 0; i < 100 && currentRate !== `LSN_RATE_HIGH; i++) @(posedge clk);
        #1;
        chk("currentRate", `LSN_RATE_HIGH, currentRate);
        chk("bwMgmtStatus", 2'h0, {1'h0, bwMgmtStatus});
        foreach (ROWS[i]) begin
            runRow(ROWS[i]);
            chk("currentRate", ROWS[i].expCur, currentRate);
            chk("bwMgmtStatus", {1'h0, ROWS[i].expBw}, {1'h0, bwMgmtStatus});
            chk("autoBwStatus", {1'h0, ROWS[i].expAuto}, {1'h0, autoBwStatus});
            chk("bwIrq", 2'h0, {1'h0, bwIrq});
            clearFlags();
        end
        // Retrain at unchanged rate, then let the flag reach the interrupt
        runRow(ROWS[4]);
        chk("bwMgmtStatus", 2'h1, {1'h0, bwMgmtStatus});
        @(posedge clk);
        bwIrqEnable <= 1'h1;
        @(posedge clk);
        #1;
        chk("bwIrq", 2'h1, {1'h0, bwIrq});
        clearFlags();
        chk("bwIrq", 2'h0, {1'h0, bwIrq});
        // Upgrade fails on the far end: stays low past the hold-off
        runRow('{4'h0, `LSN_RATE_HIGH, 1'h0, 2'h0, 1'h0, 1'h0});
        @(posedge clk) hiReliable <= 1'h0;
        fullTrain(80);
        chk("currentRate", `LSN_RATE_LOW, currentRate);
        @(posedge clk) hiReliable <= 1'h1;
        runRow(ROWS[3]);
        chk("currentRate", `LSN_RATE_HIGH, currentRate);
        // Partner without the high rate: no upgrade, retrain passes at low rate
        @(posedge clk) hiCapable <= 1'h0;
        fullTrain(60);
        chk("currentRate", `LSN_RATE_LOW, currentRate);
        clearFlags();
        runRow(ROWS[3]);
        chk("currentRate", `LSN_RATE_LOW, currentRate);
        chk("bwMgmtStatus", 2'h1, {1'h0, bwMgmtStatus});
        conclude();
    end
endmodule : link_speed_negotiation_bench
`default_nettype wire
